// ==== hdl/opfs_core.sv ====
// Functional notes
// - response 00: an over-power fault leaves the output running untouched.
// - response 10: fault disables output, then retry count in bits 5:3 governs.
// - retry code 000: no restart; output stays off until faults are cleared.
// - retry codes 001..110: attempt restart that many times, one to six.
// - when all permitted restarts fail, output latched off until faults cleared.
// - code 111 retries forever until commanded off, bias lost or other shutdown.
// - wait from each trip to the next restart is delay bits 2:0 times 200 ms.
// - warning limit is 16-bit linear watts; only exponent 3 is accepted.
// - warning flag only when measured power strictly exceeds the limit.
// - summary bit 6 reads 1 whenever the output is not delivering power.
// - bit 5 latches output overvoltage, bit 4 latches output overcurrent fault.
// - bit 3 latches input undervoltage fault.
// - bit 2 latches any temperature fault or warning.
// - bit 1 latches communication, memory or logic faults.
// - bit 0 latches any other fault or warning, incl. over-power ones.
// - enable on/off never clears latched summary flags.
module opfs_core #(
  parameter int UNIT_CYCLES = opfs_pkg::DELAY_UNIT_CYCLES
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [7:0] reg_cmd,
  input wire logic reg_wr,
  input wire logic [15:0] reg_wr_data,
  input wire logic reg_rd,
  output logic [15:0] reg_rd_data,
  output logic reg_ack,
  output logic reg_nack,
  input wire logic enable_cmd,
  input wire logic bias_ok,
  input wire logic other_shutdown,
  input wire logic op_fault,
  input wire logic [15:0] pout_meas,
  input wire opfs_pkg::opfs_evt_t evt,
  input wire logic fault_clear,
  output logic output_en,
  output logic op_warn
);

  function automatic logic signed [10:0] lin_mant(input logic [15:0] v);
    lin_mant = signed'(v[opfs_pkg::LIN_MANT_MSB:0]);
  endfunction : lin_mant

  opfs_pkg::opfs_reaction_t reaction_reg;
  opfs_pkg::opfs_reaction_t reaction_next;
  logic [15:0] warn_lim_reg;
  logic [15:0] warn_lim_next;
  opfs_pkg::opfs_state_t state_reg;
  opfs_pkg::opfs_state_t state_next;
  logic [2:0] attempts_reg;
  logic [2:0] attempts_next;
  logic [opfs_pkg::TIMER_W-1:0] timer_reg;
  logic [opfs_pkg::TIMER_W-1:0] timer_next;
  logic [5:0] sum_reg;
  logic [5:0] sum_next;
  logic [15:0] rd_data_next;
  logic ack_next;
  logic nack_next;
  logic out_next;
  logic warn_next;

  // register access decode
  wire hit_reaction = reg_cmd == opfs_pkg::CMD_OP_REACTION;
  wire hit_warn = reg_cmd == opfs_pkg::CMD_OP_WARN_LIM;
  wire hit_summary = reg_cmd == opfs_pkg::CMD_SUMMARY;
  wire [1:0] wr_resp = reg_wr_data[opfs_pkg::RESP_MSB:opfs_pkg::RESP_LSB];
  wire resp_ok = wr_resp == opfs_pkg::RESP_IGNORE || wr_resp == opfs_pkg::RESP_DISABLE;
  wire lim_ok = reg_wr_data[opfs_pkg::LIN_EXP_MSB:opfs_pkg::LIN_EXP_LSB]
    == opfs_pkg::WARN_LIM_EXP;
  wire wr_reaction = reg_wr && hit_reaction && resp_ok;
  wire wr_warn = reg_wr && hit_warn && lim_ok;
  wire wr_refused = reg_wr && !(wr_reaction || wr_warn);
  wire rd_refused = reg_rd && !(hit_reaction || hit_warn || hit_summary);

  assign reaction_next = wr_reaction ? opfs_pkg::opfs_reaction_t'(reg_wr_data[7:0])
    : reaction_reg;
  assign warn_lim_next = wr_warn ? reg_wr_data : warn_lim_reg;
  assign ack_next = (reg_wr || reg_rd) && !(wr_refused || rd_refused);
  assign nack_next = wr_refused || rd_refused;

  // summary byte, bit 7 unused here and reads zero
  wire [7:0] summary = {1'b0, !output_en, sum_reg};

  assign rd_data_next = !reg_rd ? reg_rd_data
    : hit_reaction ? {8'h00, reaction_reg}
    : hit_warn ? warn_lim_reg
    : hit_summary ? {8'h00, summary}
    : 16'h0000;

  // warning compare at the limit's own resolution; measurement uses exponent 3 too
  assign warn_next = lin_mant(pout_meas) > lin_mant(warn_lim_reg);

  // sticky flags: set beats clear; enable changes play no part
  wire [5:0] sum_set = {evt.vout_ov, evt.iout_oc, evt.vin_uv, evt.temp, evt.cml,
    evt.other || op_fault || op_warn};
  assign sum_next = sum_set | (fault_clear ? 6'h00 : sum_reg);

  // restart sequencer
  wire cmd_off = !enable_cmd || !bias_ok || other_shutdown;
  wire trip = op_fault && reaction_reg.resp == opfs_pkg::RESP_DISABLE;
  wire retries_left = reaction_reg.retries == opfs_pkg::RETRY_ENDLESS
    || attempts_reg < reaction_reg.retries;
  logic [opfs_pkg::TIMER_W-1:0] gap;
  assign gap = opfs_pkg::TIMER_W'(reaction_reg.delay) * opfs_pkg::TIMER_W'(UNIT_CYCLES);
  // a zero delay still costs one cycle before the restart
  wire [opfs_pkg::TIMER_W-1:0] gap_load = gap == '0 ? '0 : gap - 1'b1;

  always_comb begin
    state_next = state_reg;
    attempts_next = attempts_reg;
    timer_next = timer_reg;
    case (state_reg)
      opfs_pkg::OPFS_OFF: begin
        attempts_next = 3'h0;
        if (!cmd_off) begin
          state_next = opfs_pkg::OPFS_ON;
        end
      end
      opfs_pkg::OPFS_ON: begin
        if (cmd_off) begin
          state_next = opfs_pkg::OPFS_OFF;
        end else if (trip && retries_left) begin
          state_next = opfs_pkg::OPFS_WAIT;
          timer_next = gap_load;
        end else if (trip) begin
          state_next = opfs_pkg::OPFS_LATCHED;
        end
      end
      opfs_pkg::OPFS_WAIT: begin
        if (cmd_off) begin
          state_next = opfs_pkg::OPFS_OFF;
        end else if (timer_reg == '0) begin
          state_next = opfs_pkg::OPFS_ON;
          if (reaction_reg.retries != opfs_pkg::RETRY_ENDLESS) begin
            attempts_next = attempts_reg + 3'h1;
          end
        end else begin
          timer_next = timer_reg - 1'b1;
        end
      end
      opfs_pkg::OPFS_LATCHED: begin
        if (cmd_off) begin
          state_next = opfs_pkg::OPFS_OFF;
        end else if (fault_clear) begin
          state_next = opfs_pkg::OPFS_ON;
          attempts_next = 3'h0;
        end
      end
      default: begin
        state_next = opfs_pkg::OPFS_OFF;
      end
    endcase
  end

  assign out_next = state_next == opfs_pkg::OPFS_ON;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      reaction_reg <= opfs_pkg::REACTION_RST;
      warn_lim_reg <= opfs_pkg::WARN_LIM_RST;
      state_reg <= opfs_pkg::OPFS_OFF;
      attempts_reg <= 3'h0;
      timer_reg <= '0;
      sum_reg <= 6'h00;
      reg_rd_data <= 16'h0000;
      reg_ack <= 1'b0;
      reg_nack <= 1'b0;
      output_en <= 1'b0;
      op_warn <= 1'b0;
    end else begin
      reaction_reg <= reaction_next;
      warn_lim_reg <= warn_lim_next;
      state_reg <= state_next;
      attempts_reg <= attempts_next;
      timer_reg <= timer_next;
      sum_reg <= sum_next;
      reg_rd_data <= rd_data_next;
      reg_ack <= ack_next;
      reg_nack <= nack_next;
      output_en <= out_next;
      op_warn <= warn_next;
    end
  end

  // checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  sequence running_s;
    state_reg == opfs_pkg::OPFS_ON && !cmd_off;
  endsequence

  sequence tripped_s;
    running_s ##0 op_fault && reaction_reg.resp == opfs_pkg::RESP_DISABLE;
  endsequence

  ignore_keeps_on_a: assert property (
    running_s ##0 reaction_reg.resp == opfs_pkg::RESP_IGNORE |=> output_en)
    else $error("output dropped with fault ignored");

  trip_disables_a: assert property (
    tripped_s |=> !output_en)
    else $error("output stayed on after over-power trip");

  no_retry_latch_a: assert property (
    tripped_s ##0 reaction_reg.retries == opfs_pkg::RETRY_NONE
    |=> state_reg == opfs_pkg::OPFS_LATCHED)
    else $error("no-retry setting did not latch off");

  retry_count_a: assert property (
    attempts_reg <= 3'h6)
    else $error("restart count beyond six");

  exhausted_latch_a: assert property (
    tripped_s ##0 reaction_reg.retries != opfs_pkg::RETRY_ENDLESS
    ##0 attempts_reg >= reaction_reg.retries |=> !output_en [*2])
    else $error("restart after retries exhausted");

  cmd_off_stops_a: assert property (
    cmd_off |=> !output_en && state_reg != opfs_pkg::OPFS_WAIT)
    else $error("retrying while commanded off");

  retry_gap_a: assert property (
    state_reg == opfs_pkg::OPFS_WAIT && timer_reg == '0 && !cmd_off |=> output_en)
    else $error("restart not issued at end of delay");

  gap_load_a: assert property (
    tripped_s ##0 retries_left |=> timer_reg == $past(gap_load))
    else $error("retry delay loaded wrong");

  lim_exp_a: assert property (
    reg_wr && hit_warn && !lim_ok |=> reg_nack && $stable(warn_lim_reg))
    else $error("limit with wrong exponent accepted");

  warn_strict_a: assert property (
    lin_mant(pout_meas) == lin_mant(warn_lim_reg) |=> !op_warn)
    else $error("warning raised at equal power");

  off_bit_a: assert property (
    reg_rd && hit_summary |=> reg_rd_data[opfs_pkg::SUM_OFF] == !$past(output_en))
    else $error("off bit disagrees with output");

  ov_sticky_a: assert property (
    evt.vout_ov ##1 !fault_clear |-> sum_reg[opfs_pkg::SUM_VOUT_OV] ##1
    sum_reg[opfs_pkg::SUM_VOUT_OV])
    else $error("overvoltage flag lost without clear");

  uv_set_a: assert property (
    evt.vin_uv |=> sum_reg[opfs_pkg::SUM_VIN_UV])
    else $error("undervoltage flag not set");

  flags_kept_a: assert property (
    !fault_clear && $changed(enable_cmd) |=> (sum_reg & $past(sum_reg)) == $past(sum_reg))
    else $error("enable change cleared a flag");

  other_set_a: assert property (
    op_warn |=> sum_reg[opfs_pkg::SUM_OTHER])
    else $error("over-power warning not reported");

  reserved_resp_a: assert property (
    reg_wr && hit_reaction && !resp_ok |=> $stable(reaction_reg) && reg_nack)
    else $error("reserved response code accepted");

  // restart and countdown steps of the wait state
  sequence restart_s;
    state_reg == opfs_pkg::OPFS_WAIT && timer_reg == '0 && !cmd_off;
  endsequence

  sequence waiting_s;
    state_reg == opfs_pkg::OPFS_WAIT && timer_reg != '0 && !cmd_off;
  endsequence

  iout_set_a: assert property (
    evt.iout_oc |=> sum_reg[opfs_pkg::SUM_IOUT_OC])
    else $error("overcurrent flag not set");

  temp_set_a: assert property (
    evt.temp |=> sum_reg[opfs_pkg::SUM_TEMP])
    else $error("temperature flag not set");

  cml_set_a: assert property (
    evt.cml |=> sum_reg[opfs_pkg::SUM_CML])
    else $error("communication flag not set");

  other_evt_a: assert property (
    evt.other |=> sum_reg[opfs_pkg::SUM_OTHER])
    else $error("other fault flag not set");

  op_fault_flag_a: assert property (
    op_fault |=> sum_reg[opfs_pkg::SUM_OTHER])
    else $error("over-power fault not reported");

  uv_sticky_a: assert property (
    sum_reg[opfs_pkg::SUM_VIN_UV] && !fault_clear |=> sum_reg[opfs_pkg::SUM_VIN_UV])
    else $error("undervoltage flag dropped");

  flags_hold_a: assert property (
    !fault_clear |=> (sum_reg & $past(sum_reg)) == $past(sum_reg))
    else $error("flag dropped without clear");

  warn_above_a: assert property (
    lin_mant(pout_meas) > lin_mant(warn_lim_reg) |=> op_warn)
    else $error("warning missing above limit");

  warn_below_a: assert property (
    lin_mant(pout_meas) < lin_mant(warn_lim_reg) |=> !op_warn)
    else $error("warning raised below limit");

  lim_write_a: assert property (
    reg_wr && hit_warn && lim_ok |=> warn_lim_reg == $past(reg_wr_data) && reg_ack)
    else $error("valid limit write not taken");

  reaction_write_a: assert property (
    reg_wr && hit_reaction && resp_ok |=> reaction_reg == $past(reg_wr_data[7:0]) && reg_ack)
    else $error("valid reaction write not taken");

  summary_ro_a: assert property (
    reg_wr && hit_summary |=> reg_nack && !reg_ack)
    else $error("summary byte took a write");

  bit7_zero_a: assert property (
    reg_rd && hit_summary |=> reg_rd_data[7] == 1'b0)
    else $error("unused summary bit set");

  ack_excl_a: assert property (
    !(reg_ack && reg_nack))
    else $error("accept and refuse together");

  latched_off_a: assert property (
    state_reg == opfs_pkg::OPFS_LATCHED && !cmd_off && !fault_clear |=> !output_en)
    else $error("output back on while latched");

  latched_stays_a: assert property (
    state_reg == opfs_pkg::OPFS_LATCHED && !cmd_off && !fault_clear
    |=> state_reg == opfs_pkg::OPFS_LATCHED)
    else $error("latched state left without clear");

  wait_count_a: assert property (
    waiting_s |=> state_reg == opfs_pkg::OPFS_WAIT && timer_reg == $past(timer_reg) - 1'b1)
    else $error("retry delay not counting down");

  restart_count_a: assert property (
    restart_s ##0 reaction_reg.retries != opfs_pkg::RETRY_ENDLESS
    |=> attempts_reg == $past(attempts_reg) + 3'h1)
    else $error("restart attempt not counted");

  endless_count_a: assert property (
    restart_s ##0 reaction_reg.retries == opfs_pkg::RETRY_ENDLESS
    |=> attempts_reg == $past(attempts_reg))
    else $error("endless retry counted attempts");

  off_count_a: assert property (
    state_reg == opfs_pkg::OPFS_OFF |=> attempts_reg == 3'h0)
    else $error("attempt count kept while off");

  ignore_stays_a: assert property (
    running_s ##0 reaction_reg.resp == opfs_pkg::RESP_IGNORE
    |=> state_reg == opfs_pkg::OPFS_ON)
    else $error("ignored fault left running state");

  trip_waits_a: assert property (
    tripped_s ##0 retries_left |=> state_reg == opfs_pkg::OPFS_WAIT)
    else $error("trip with retries left did not wait");

endmodule : opfs_core

// ==== hdl/opfs_pkg.sv ====
package opfs_pkg;
  // management command codes
  localparam logic [7:0] CMD_OP_REACTION = 8'h69;
  localparam logic [7:0] CMD_OP_WARN_LIM = 8'h6a;
  localparam logic [7:0] CMD_SUMMARY = 8'h78;

  // reaction byte fields
  localparam int RESP_MSB = 7;
  localparam int RESP_LSB = 6;
  localparam int RETRY_MSB = 5;
  localparam int RETRY_LSB = 3;
  localparam int DELAY_MSB = 2;
  localparam int DELAY_LSB = 0;
  localparam logic [1:0] RESP_IGNORE = 2'h0;
  localparam logic [1:0] RESP_DISABLE = 2'h2;
  localparam logic [2:0] RETRY_NONE = 3'h0;
  localparam logic [2:0] RETRY_ENDLESS = 3'h7;

  // linear format
  localparam int LIN_EXP_MSB = 15;
  localparam int LIN_EXP_LSB = 11;
  localparam int LIN_MANT_MSB = 10;
  localparam logic [4:0] WARN_LIM_EXP = 5'h03;

  // summary byte bit positions
  localparam int SUM_OFF = 6;
  localparam int SUM_VOUT_OV = 5;
  localparam int SUM_IOUT_OC = 4;
  localparam int SUM_VIN_UV = 3;
  localparam int SUM_TEMP = 2;
  localparam int SUM_CML = 1;
  localparam int SUM_OTHER = 0;

  // reset values
  localparam logic [7:0] REACTION_RST = 8'h80;
  localparam logic [15:0] WARN_LIM_RST = 16'h1bff;

  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int DELAY_UNIT_MS = 200;
  localparam int DELAY_UNIT_CYCLES = DELAY_UNIT_MS * (1000000 / CLK_PERIOD_NS);
  localparam int TIMER_W = 28;

  typedef enum logic [1:0] {
    OPFS_OFF,
    OPFS_ON,
    OPFS_WAIT,
    OPFS_LATCHED
  } opfs_state_t;

  // latched fault events from the rest of the converter
  typedef struct packed {
    logic vout_ov;
    logic iout_oc;
    logic vin_uv;
    logic temp;
    logic cml;
    logic other;
  } opfs_evt_t;

  typedef struct packed {
    logic [1:0] resp;
    logic [2:0] retries;
    logic [2:0] delay;
  } opfs_reaction_t;
endpackage : opfs_pkg

// ==== verification/opfs_host.sv ====
module opfs_host (
  input wire logic ref_clk,
  output logic [7:0] reg_cmd,
  output logic reg_wr,
  output logic [15:0] reg_wr_data,
  output logic reg_rd,
  input wire logic [15:0] reg_rd_data,
  input wire logic reg_ack,
  input wire logic reg_nack
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    reg_cmd = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wr_data = 16'h0000;
  end
  // one strobe per access; answer taken 1 ns after the taking edge
  task automatic access(input logic wr, input logic [7:0] cmd, input logic [15:0] wd,
                        output logic [15:0] rd, output logic [1:0] rsp);
    @(posedge ref_clk);
    reg_cmd <= cmd;
    reg_wr <= wr;
    reg_rd <= !wr;
    reg_wr_data <= wd;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    reg_wr_data <= ~wd;  // released data goes to junk, stale value would hide bugs
    #1;
    rd = reg_rd_data;
    rsp = {reg_ack, reg_nack};
  endtask : access
endmodule : opfs_host

// ==== verification/overpower_fault_status_logic_test.sv ====
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
  $display("ERROR %s exp %h got %h", nm, e, g); end end
module overpower_fault_status_logic_test;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic wr;
    logic [7:0] cmd;
    logic [15:0] wd;
    logic [1:0] rsp;
    logic [15:0] rd;
  } opfs_row_t;
  localparam opfs_row_t ROWS [11] = '{
    '{1'b0, 8'h69, 16'h0000, 2'b10, 16'h0080}, '{1'b0, 8'h6a, 16'h0000, 2'b10, 16'h1bff},
    '{1'b0, 8'h78, 16'h0000, 2'b10, 16'h0040}, '{1'b1, 8'h69, 16'h0040, 2'b01, 16'h0000},
    '{1'b1, 8'h69, 16'h00c0, 2'b01, 16'h0000}, '{1'b0, 8'h69, 16'h0000, 2'b10, 16'h0080},
    '{1'b1, 8'h6a, 16'h2064, 2'b01, 16'h0000}, '{1'b1, 8'h78, 16'h0000, 2'b01, 16'h0000},
    '{1'b0, 8'h55, 16'h0000, 2'b01, 16'h0000}, '{1'b1, 8'h6a, 16'h1864, 2'b10, 16'h0000},
    '{1'b0, 8'h6a, 16'h0000, 2'b10, 16'h1864}};
  logic ref_clk, reset, reg_wr, reg_rd, reg_ack, reg_nack, enable_cmd, bias_ok;
  logic other_shutdown, op_fault, fault_clear, output_en, op_warn;
  logic [7:0] reg_cmd, acc;
  logic [15:0] reg_wr_data, reg_rd_data, pout_meas, rd;
  logic [1:0] rsp;
  opfs_pkg::opfs_evt_t evt;
  int error_cnt, n_tests, cyc, n;
  opfs_core #(.UNIT_CYCLES(4)) i_opfs_core (.ref_clk(ref_clk), .reset(reset),
    .reg_cmd(reg_cmd), .reg_wr(reg_wr), .reg_wr_data(reg_wr_data), .reg_rd(reg_rd),
    .reg_rd_data(reg_rd_data), .reg_ack(reg_ack), .reg_nack(reg_nack),
    .enable_cmd(enable_cmd), .bias_ok(bias_ok), .other_shutdown(other_shutdown),
    .op_fault(op_fault), .pout_meas(pout_meas), .evt(evt), .fault_clear(fault_clear),
    .output_en(output_en), .op_warn(op_warn));
  opfs_host i_opfs_host (.ref_clk(ref_clk), .reg_cmd(reg_cmd), .reg_wr(reg_wr),
    .reg_wr_data(reg_wr_data), .reg_rd(reg_rd), .reg_rd_data(reg_rd_data),
    .reg_ack(reg_ack), .reg_nack(reg_nack));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic tally_and_finish;
    if (error_cnt == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      tally_and_finish;
    end
  end
  // cycles until output comes back, capped at 60 so a latched-off state reads 60
  task automatic count_up;
    n = 0;
    do begin
      @(posedge ref_clk);
      #1;
      n++;
    end while (!output_en && n < 60);
  endtask : count_up
  task automatic wr_reg(input logic [15:0] d);
    i_opfs_host.access(1'b1, 8'h69, d, rd, rsp);
    `CHK("reaction write", 2'b10, rsp)
  endtask : wr_reg
  task automatic rd_sum(input logic [7:0] e);
    i_opfs_host.access(1'b0, 8'h78, 16'h0000, rd, rsp);
    `CHK("summary", {8'h00, e}, rd)
  endtask : rd_sum
  // lo and lo+1 both accepted: wait count edge alignment left open
  task automatic trip(input logic keep, input int lo);
    @(posedge ref_clk);
    op_fault <= 1'b1;
    @(posedge ref_clk);
    op_fault <= 1'b0;
    #1;
    `CHK("output after trip", keep, output_en)
    count_up;
    `CHK("restart cycles", 1'b1, n >= lo && n <= lo + 1)
  endtask : trip
  task automatic clear_fault;
    @(posedge ref_clk);
    fault_clear <= 1'b1;
    @(posedge ref_clk);
    fault_clear <= 1'b0;
    count_up;
    `CHK("restart after clear", 1'b1, n < 60)
  endtask : clear_fault
  initial begin
    {reset, bias_ok} = 2'b11;
    {enable_cmd, other_shutdown, op_fault, fault_clear} = 4'h0;
    pout_meas = 16'h0000;
    evt = '0;
    error_cnt = 0;
    n_tests = 0;
    cyc = 0;
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    foreach (ROWS[i]) begin
      i_opfs_host.access(ROWS[i].wr, ROWS[i].cmd, ROWS[i].wd, rd, rsp);
      `CHK("answer", ROWS[i].rsp, rsp)
      if (!ROWS[i].wr) `CHK("read data", ROWS[i].rd, rd)
    end
    @(posedge ref_clk);
    enable_cmd <= 1'b1;
    count_up;
    rd_sum(8'h00);
    for (int p = 0; p < 2; p++) begin
      @(posedge ref_clk);
      pout_meas <= 16'h1864 + 16'(p);
      repeat (3) @(posedge ref_clk);
      #1;
      `CHK("warning", p[0], op_warn)
    end
    @(posedge ref_clk);
    pout_meas <= 16'h0000;
    acc = 8'h01;
    rd_sum(acc);
    for (int k = 5; k >= 0; k--) begin
      @(posedge ref_clk);
      evt <= opfs_pkg::opfs_evt_t'(6'h01 << k);
      @(posedge ref_clk);
      evt <= '0;
      acc = acc | (8'h01 << k);
      rd_sum(acc);
    end
    @(posedge ref_clk);
    enable_cmd <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rd_sum(acc | 8'h40);
    @(posedge ref_clk);
    enable_cmd <= 1'b1;
    count_up;
    rd_sum(acc);
    wr_reg(16'h0000);
    trip(1'b1, 1);
    for (int r = 0; r < 7; r++) begin
      wr_reg({8'h00, 2'b10, r[2:0], 3'b000});
      repeat (r) trip(1'b0, 1);
      trip(1'b0, 60);
      clear_fault;
    end
    wr_reg(16'h00bf);
    repeat (8) trip(1'b0, 28);
    @(posedge ref_clk);
    op_fault <= 1'b1;
    @(posedge ref_clk);
    op_fault <= 1'b0;
    bias_ok <= 1'b0;  // bias lost mid-wait must stop endless retry
    count_up;
    `CHK("retry stopped", 60, n)
    @(posedge ref_clk);
    bias_ok <= 1'b1;
    count_up;
    @(posedge ref_clk);
    op_fault <= 1'b1;
    @(posedge ref_clk);
    op_fault <= 1'b0;
    other_shutdown <= 1'b1;  // another fault's shutdown must also end endless retry
    count_up;
    `CHK("shutdown stops retry", 60, n)
    @(posedge ref_clk);
    {reset, enable_cmd, bias_ok, other_shutdown} <= 4'b1010;
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    i_opfs_host.access(1'b0, 8'h69, 16'h0000, rd, rsp);
    `CHK("reaction after reset", 16'h0080, rd)
    rd_sum(8'h40);
    tally_and_finish;
  end
endmodule : overpower_fault_status_logic_test
